/* File: hdl/extra_axis_defines.svh */
// offsets, field positions, reset values and timing for the extra axis interlock
`ifndef EXTRA_AXIS_DEFINES_SVH
`define EXTRA_AXIS_DEFINES_SVH
`define OFS_W 6
`define OFS_CTRL 6'h00
`define OFS_DELAY 6'h04
`define OFS_STATUS 6'h08
`define OFS_MASK 6'h0C
`define OFS_LIVE 6'h10
`define CARD_LSB 6
`define CARD_MSB 7
`define CTRL_W 3
`define CTRL_DRIVE 0
`define CTRL_INNER_EN 1
`define CTRL_OUTER_EN 2
`define CTRL_RESET 3'h6
`define EV_W 6
`define EV_CONTACTOR 0
`define EV_AMP 1
`define EV_OUTER 2
`define EV_INNER 3
`define EV_ESTOP_ACK 4
`define EV_REF 5
`define EV_RESET 6'h00
`define MASK_RESET 6'h00
`define LIVE_W 14
`define CHAN_RESET 2'h0
`define CONFIRM_MS 10
`define CLOCK_HZ 10000000
`define MS_PER_S 1000
`endif

/* File: hdl/extra_axis_pkg.sv */
// types shared by the extra axis interlock modules
package extra_axis_pkg;
   typedef enum logic [4:0] {
      IDLE = 5'h01,
      ENGAGE = 5'h02,
      RUN = 5'h04,
      HOLD = 5'h08,
      TRIP = 5'h10
   } drive_state_t;
endpackage

/* File: hdl/event_if.sv */
// sticky event bundle between the interlock and its status bank
`timescale 1ns/10ps
interface event_if #(parameter int W = 6);
   logic [W-1:0] evt;
   logic [W-1:0] clr;
   logic [W-1:0] maskBits;
   logic [W-1:0] status;
   logic irq;
   modport owner (output evt, output clr, output maskBits, input status, input irq);
   modport bank (input evt, input clr, input maskBits, output status, output irq);
endinterface

/* File: hdl/status_bank.sv */
// sticky write-one-to-clear status bits with masked interrupt
`timescale 1ns/10ps
`include "extra_axis_defines.svh"
module status_bank #(
   parameter int W = 6
) (
   input wire logic clock,
   input wire logic nrst,
   event_if.bank ev
);
   logic [W-1:0] status_reg;
   logic [W-1:0] status_next;

   if (W < 1) begin : g_bad_width
      $error("status_bank needs at least one bit");
   end

   // set beats clear so an event in the clearing cycle survives
   always_comb begin
      status_next = (status_reg & ~ev.clr) | ev.evt;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         status_reg <= W'(`EV_RESET);
      end else begin
         status_reg <= status_next;
      end
   end

   assign ev.status = status_reg;
   assign ev.irq = |(status_reg & ev.maskBits);
endmodule // status_bank

/* File: hdl/extra_axis_drive_interlock.sv */
// drive interlock for a plug-in extra axis card with apb registers
`timescale 1ns/10ps
`include "extra_axis_defines.svh"
// How it works
// - up to four cards, each at own address
// - two straps pick channel one to four
// - function strap: table off, linear axis on
// - table mode: shared pin is reference switch
// - amplifier ok low means healthy, else fault
// - contactor feedback low means motor power present
// - feedback missing after delay: drop drives, report
// - contactor output on exactly while energising
// - forward emergency stop on its own output
// - capture amplifier emergency stop acknowledge
// - limit reactions configured by host
// - engage only with both outer limits closed
// - inner limit: decelerate, hold under servo
// - outer limit: disengage all drives at once
module extra_axis_drive_interlock #(
   parameter int DELAY_W = 20,
   parameter int CONFIRM_CYCLES = (`CONFIRM_MS * `CLOCK_HZ) / `MS_PER_S
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] channelSel,
   input wire logic axisModeSel,
   input wire logic refOrOuterPosN,
   input wire logic outerNegN,
   input wire logic innerPosN,
   input wire logic innerNegN,
   input wire logic ampOkN,
   input wire logic contactorFbN,
   input wire logic estopTripped,
   input wire logic emergencyStopIn,
   input wire logic emergencyStopClearIn,
   output logic contactorOn,
   output logic ampEnable,
   output logic emergencyStopLoopOut,
   output logic decelRequest,
   output logic irq
);
   event_if #(.W(`EV_W)) ev ();

   extra_axis_pkg::drive_state_t state_reg;
   extra_axis_pkg::drive_state_t state_next;
   logic strapDone_reg;
   logic [1:0] cardChannel_reg;
   logic axisMode_reg;
   logic [`CTRL_W-1:0] ctrl_reg;
   logic [DELAY_W-1:0] confirmDelay_reg;
   logic [`EV_W-1:0] mask_reg;
   logic [DELAY_W-1:0] count_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic estopAck_reg;
   logic refIn_reg;
   logic [`OFS_W-1:0] ofs;
   logic cardHit;
   logic wrEn;
   logic mapped;
   logic [`LIVE_W-1:0] liveBits;
   logic ampHealthy;
   logic motorPower;
   logic refSwitch;
   logic outerPosHit;
   logic outerNegHit;
   logic innerAny;
   logic outerAny;
   logic outersClosed;
   logic driveWanted;
   logic innerStopEn;
   logic outerStopEn;
   logic timeout;
   logic energised;

   // refused at elaboration: the counter could not hold the confirmation delay
   if (DELAY_W < 2 || DELAY_W > 32) begin : g_bad_width
      $error("DELAY_W must lie in 2..32");
   end
   if (CONFIRM_CYCLES < 1 || CONFIRM_CYCLES >= (64'h1 << DELAY_W)) begin : g_bad_confirm
      $error("CONFIRM_CYCLES does not fit DELAY_W");
   end

   status_bank #(.W(`EV_W)) bank (
      .clock(clock),
      .nrst(nrst),
      .ev(ev)
   );

   // straps are sampled once after reset release, never at the reset edge
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         strapDone_reg <= 1'b0;
         cardChannel_reg <= `CHAN_RESET;
         axisMode_reg <= 1'b0;
      end else if (!strapDone_reg) begin
         strapDone_reg <= 1'b1;
         cardChannel_reg <= channelSel;
         axisMode_reg <= axisModeSel;
      end
   end

   // pin meaning depends on function strap; closed switch pulls low
   assign ampHealthy = !ampOkN;
   assign motorPower = !contactorFbN;
   // gated by strap latch: mode reads table before it, so a closed outer limit would look like a reference edge
   assign refSwitch = strapDone_reg && !axisMode_reg && !refOrOuterPosN;
   assign outerPosHit = axisMode_reg && refOrOuterPosN;
   assign outerNegHit = axisMode_reg && outerNegN;
   assign innerAny = axisMode_reg && (innerPosN || innerNegN);
   assign outerAny = outerPosHit || outerNegHit;
   assign outersClosed = !outerAny;
   assign driveWanted = ctrl_reg[`CTRL_DRIVE];
   assign innerStopEn = ctrl_reg[`CTRL_INNER_EN];
   assign outerStopEn = ctrl_reg[`CTRL_OUTER_EN];

   // apb decode: upper address bits must match this card's channel
   assign ofs = paddr[`OFS_W-1:0];
   assign cardHit = psel && strapDone_reg && (paddr[`CARD_MSB:`CARD_LSB] == cardChannel_reg);
   assign wrEn = cardHit && penable && pwrite;
   assign mapped = (ofs == `OFS_CTRL) || (ofs == `OFS_DELAY) || (ofs == `OFS_STATUS)
      || (ofs == `OFS_MASK) || (ofs == `OFS_LIVE);
   assign pready = 1'b1;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg && penable;

   assign liveBits = {state_reg, cardChannel_reg, axisMode_reg, outerAny, innerAny,
      refSwitch, estopTripped, motorPower, ampHealthy};

   // read data and error are prepared in the setup cycle so they come from flops
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         prdata_reg <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else if (psel && !penable) begin
         prdata_reg <= 32'h00000000;
         pslverr_reg <= cardHit && !mapped;
         if (cardHit && !pwrite) begin
            case (ofs)
               `OFS_CTRL: prdata_reg <= 32'(ctrl_reg);
               `OFS_DELAY: prdata_reg <= 32'(confirmDelay_reg);
               `OFS_STATUS: prdata_reg <= 32'(ev.status);
               `OFS_MASK: prdata_reg <= 32'(mask_reg);
               `OFS_LIVE: prdata_reg <= 32'(liveBits);
               default: prdata_reg <= 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (wrEn && ofs == `OFS_CTRL) begin
         ctrl_reg <= pwdata[`CTRL_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         confirmDelay_reg <= DELAY_W'(CONFIRM_CYCLES);
      end else if (wrEn && ofs == `OFS_DELAY) begin
         confirmDelay_reg <= pwdata[DELAY_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mask_reg <= `MASK_RESET;
      end else if (wrEn && ofs == `OFS_MASK) begin
         mask_reg <= pwdata[`EV_W-1:0];
      end
   end

   assign ev.maskBits = mask_reg;
   assign ev.clr = (wrEn && ofs == `OFS_STATUS) ? pwdata[`EV_W-1:0] : `EV_W'(0);
   assign irq = ev.irq;

   // edge detectors on synchronous inputs for acknowledge and reference events
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         estopAck_reg <= 1'b0;
         refIn_reg <= 1'b0;
      end else begin
         estopAck_reg <= estopTripped;
         refIn_reg <= refSwitch;
      end
   end

   // contactor confirmation countdown, reloaded whenever not engaging
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count_reg <= DELAY_W'(CONFIRM_CYCLES);
      end else if (state_reg != extra_axis_pkg::ENGAGE) begin
         count_reg <= confirmDelay_reg;
      end else if (count_reg != DELAY_W'(0)) begin
         count_reg <= count_reg - DELAY_W'(1);
      end
   end

   assign timeout = (state_reg == extra_axis_pkg::ENGAGE) && (count_reg == DELAY_W'(0)) && !motorPower;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         extra_axis_pkg::IDLE: begin
            // refuse to engage unless both outer limits are closed
            if (driveWanted && outersClosed && ampHealthy && !emergencyStopIn && strapDone_reg) begin
               state_next = extra_axis_pkg::ENGAGE;
            end
         end
         extra_axis_pkg::ENGAGE: begin
            if (!driveWanted) begin
               state_next = extra_axis_pkg::IDLE;
            end else if (!ampHealthy || emergencyStopIn || timeout || (outerStopEn && outerAny)) begin
               state_next = extra_axis_pkg::TRIP;
            end else if (motorPower) begin
               state_next = extra_axis_pkg::RUN;
            end
         end
         extra_axis_pkg::RUN: begin
            if (!driveWanted) begin
               state_next = extra_axis_pkg::IDLE;
            end else if (!ampHealthy || emergencyStopIn || !motorPower || (outerStopEn && outerAny)) begin
               state_next = extra_axis_pkg::TRIP;
            end else if (innerStopEn && innerAny) begin
               state_next = extra_axis_pkg::HOLD;
            end
         end
         extra_axis_pkg::HOLD: begin
            // drives stay on so the axes are held, not dropped
            if (!driveWanted) begin
               state_next = extra_axis_pkg::IDLE;
            end else if (!ampHealthy || emergencyStopIn || !motorPower || (outerStopEn && outerAny)) begin
               state_next = extra_axis_pkg::TRIP;
            end else if (!innerAny) begin
               state_next = extra_axis_pkg::RUN;
            end
         end
         extra_axis_pkg::TRIP: begin
            // restart needs software to drop the request or the reset pin in axis mode
            if (!driveWanted || (axisMode_reg && emergencyStopClearIn)) begin
               state_next = extra_axis_pkg::IDLE;
            end
         end
         default: state_next = extra_axis_pkg::IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= extra_axis_pkg::IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_comb begin
      ev.evt = `EV_W'(0);
      ev.evt[`EV_CONTACTOR] = timeout
         || ((state_reg == extra_axis_pkg::RUN || state_reg == extra_axis_pkg::HOLD) && !motorPower);
      ev.evt[`EV_AMP] = energised && !ampHealthy;
      ev.evt[`EV_OUTER] = energised && outerStopEn && outerAny;
      ev.evt[`EV_INNER] = (state_reg == extra_axis_pkg::RUN) && (state_next == extra_axis_pkg::HOLD);
      ev.evt[`EV_ESTOP_ACK] = estopTripped && !estopAck_reg;
      ev.evt[`EV_REF] = refSwitch && !refIn_reg;
   end

   // outputs are state bits, so a trip drops them on the very next edge
   assign energised = (state_reg == extra_axis_pkg::ENGAGE) || (state_reg == extra_axis_pkg::RUN)
      || (state_reg == extra_axis_pkg::HOLD);
   assign contactorOn = energised;
   assign ampEnable = energised;
   assign decelRequest = (state_reg == extra_axis_pkg::HOLD);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         emergencyStopLoopOut <= 1'b0;
      end else begin
         emergencyStopLoopOut <= emergencyStopIn;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   property p_drive_pair;
      contactorOn == ampEnable;
   endproperty
   a_drive_pair: assert property (p_drive_pair) else $error("amp enable differs from contactor");

   property p_outer_drop;
      (state_reg == extra_axis_pkg::RUN && driveWanted && outerStopEn && outerAny) |=> !contactorOn && !ampEnable;
   endproperty
   a_outer_drop: assert property (p_outer_drop) else $error("outer limit did not drop drives");

   property p_engage_outer;
      $rose(contactorOn) |-> $past(outersClosed);
   endproperty
   a_engage_outer: assert property (p_engage_outer) else $error("engaged with an outer limit open");

   property p_amp_fault;
      (energised && ampOkN) |=> !contactorOn ##0 ev.status[`EV_AMP];
   endproperty
   a_amp_fault: assert property (p_amp_fault) else $error("amplifier fault not acted on");

   property p_timeout;
      (timeout && driveWanted) |=> state_reg == extra_axis_pkg::TRIP && ev.status[`EV_CONTACTOR];
   endproperty
   a_timeout: assert property (p_timeout) else $error("contactor timeout not flagged");

   property p_delay_len;
      (state_reg == extra_axis_pkg::IDLE && state_next == extra_axis_pkg::ENGAGE && confirmDelay_reg == DELAY_W'(3))
         ##1 (contactorFbN && driveWanted && ampHealthy && !emergencyStopIn && outersClosed) [*4]
         |-> state_reg == extra_axis_pkg::ENGAGE ##1 state_reg == extra_axis_pkg::TRIP;
   endproperty
   a_delay_len: assert property (p_delay_len) else $error("confirmation delay length wrong");

   property p_fb_loss;
      (state_reg == extra_axis_pkg::RUN && contactorFbN) |=> !contactorOn;
   endproperty
   a_fb_loss: assert property (p_fb_loss) else $error("lost motor power not acted on");

   property p_estop_fwd;
      ##1 emergencyStopLoopOut == $past(emergencyStopIn);
   endproperty
   a_estop_fwd: assert property (p_estop_fwd) else $error("emergency stop not forwarded");

   property p_inner_hold;
      (state_reg == extra_axis_pkg::RUN && state_next == extra_axis_pkg::HOLD) |=> decelRequest && contactorOn;
   endproperty
   a_inner_hold: assert property (p_inner_hold) else $error("inner limit did not hold axes");

   property p_ack_capture;
      $rose(estopTripped) |=> ev.status[`EV_ESTOP_ACK];
   endproperty
   a_ack_capture: assert property (p_ack_capture) else $error("estop acknowledge not captured");

   property p_ref_capture;
      (!axisMode_reg && $fell(refOrOuterPosN) && strapDone_reg) |=> ev.status[`EV_REF];
   endproperty
   a_ref_capture: assert property (p_ref_capture) else $error("reference switch not captured");

   property p_table_no_limits;
      (!axisMode_reg && strapDone_reg && state_reg == extra_axis_pkg::RUN && driveWanted && ampHealthy
         && !emergencyStopIn && motorPower) |=> state_reg == extra_axis_pkg::RUN;
   endproperty
   a_table_no_limits: assert property (p_table_no_limits) else $error("limits active in table mode");

   property p_foreign_write;
      (psel && penable && pwrite && !cardHit) |=> $stable(ctrl_reg) && $stable(mask_reg);
   endproperty
   a_foreign_write: assert property (p_foreign_write) else $error("write taken at another card address");

   c_run: cover property (state_reg == extra_axis_pkg::ENGAGE ##1 state_reg == extra_axis_pkg::RUN);
   c_hold: cover property (state_reg == extra_axis_pkg::HOLD ##1 state_reg == extra_axis_pkg::RUN);
   c_timeout: cover property (timeout ##1 state_reg == extra_axis_pkg::TRIP);
   c_irq: cover property ($rose(irq));
endmodule // extra_axis_drive_interlock

/* File: testbench/servo_amp_model.sv */
// behavioural servo amplifier and contactor at the far side of the interlock
`timescale 1ns/10ps
module servo_amp_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic contactorOn,
   input wire logic ampEnable,
   input wire logic emergencyStopLoopOut,
   input wire logic ampFault,
   input wire logic fbStuck,
   output logic ampOkN,
   output logic contactorFbN,
   output logic estopTripped
);
   logic [1:0] pullIn;
   // healthy amplifier pulls its ok line low
   assign ampOkN = ampFault;
   // contactor closes two cycles after its coil is driven; stuck models a welded-open contactor
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pullIn <= 2'h0;
      end else begin
         pullIn <= {pullIn[0], contactorOn};
      end
   end
   assign contactorFbN = !(pullIn[1] && !fbStuck);
   // acknowledge comes one cycle after the loop drops; enable is not needed for it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         estopTripped <= 1'b0;
      end else begin
         estopTripped <= emergencyStopLoopOut;
      end
   end
endmodule // servo_amp_model

/* File: testbench/extra_axis_drive_interlock_tb_top.sv */
// self-checking bench for the extra axis drive interlock
`timescale 1ns/10ps
`include "extra_axis_defines.svh"
module extra_axis_drive_interlock_tb_top;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, errSeen;
   logic [1:0] channelSel = 2'h1;
   logic axisModeSel = 1'b1, refOrOuterPosN = 1'b0, outerNegN = 1'b0, innerPosN = 1'b0, innerNegN = 1'b0;
   logic estopIn = 1'b0, estopClear = 1'b0, ampFault = 1'b0, fbStuck = 1'b0;
   logic ampOkN, contactorFbN, estopTripped, contactorOn, ampEnable, loopOut, decelRequest, irq;
   int mismatches = 0;
   int compares = 0;
   always #50 clock = ~clock;
   extra_axis_drive_interlock #(.DELAY_W(20), .CONFIRM_CYCLES(8)) i_extra_axis_drive_interlock (
      .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .channelSel(channelSel),
      .axisModeSel(axisModeSel), .refOrOuterPosN(refOrOuterPosN), .outerNegN(outerNegN),
      .innerPosN(innerPosN), .innerNegN(innerNegN), .ampOkN(ampOkN), .contactorFbN(contactorFbN),
      .estopTripped(estopTripped), .emergencyStopIn(estopIn), .emergencyStopClearIn(estopClear),
      .contactorOn(contactorOn), .ampEnable(ampEnable), .emergencyStopLoopOut(loopOut),
      .decelRequest(decelRequest), .irq(irq));
   servo_amp_model i_servo_amp_model (.clock(clock), .nrst(nrst), .contactorOn(contactorOn),
      .ampEnable(ampEnable), .emergencyStopLoopOut(loopOut), .ampFault(ampFault), .fbStuck(fbStuck),
      .ampOkN(ampOkN), .contactorFbN(contactorFbN), .estopTripped(estopTripped));
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // setup cycle, then access held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] o, input logic [31:0] d);
      apb(1'b1, {channelSel, o}, d);
   endtask
   task automatic rdchk(input string name, input logic [5:0] o, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, {channelSel, o}, 32'h0);
      chk(name, rd & m, exp);
   endtask
   // restart the drive with clean status
   task automatic rearm();
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_STATUS, 32'h3F);
      wr(`OFS_CTRL, 32'h7);
      cyc(6);
   endtask
   initial begin
      #(20000 * 100);
      mismatches++;
      complete_run();
   end
   initial begin
      cyc(4);
      nrst <= 1'b1;
      cyc(2);
      rdchk("ctrl", `OFS_CTRL, 32'hFFFFFFFF, 32'h6);
      rdchk("delay", `OFS_DELAY, 32'hFFFFFFFF, 32'h8);
      rdchk("status", `OFS_STATUS, 32'hFFFFFFFF, 32'h0);
      rdchk("mask", `OFS_MASK, 32'hFFFFFFFF, 32'h0);
      rdchk("chan", `OFS_LIVE, 32'h1C0, 32'hC0);
      apb(1'b0, 8'h00, 32'h0);
      chk("other", rd, 32'h0);
      apb(1'b1, 8'h00, 32'h7);
      cyc(3);
      chk("otherwr", contactorOn, 1'b0);
      apb(1'b0, {channelSel, 6'h14}, 32'h0);
      chk("slverr", errSeen, 1'b1);
      chk("ready", pready, 1'b1);
      $display("test registers done");
      wr(`OFS_MASK, 32'h3F);
      wr(`OFS_DELAY, 32'h3);
      wr(`OFS_CTRL, 32'h7);
      cyc(2);
      chk("cont", contactorOn, 1'b1);
      chk("amp", ampEnable, 1'b1);
      cyc(4);
      rdchk("run", `OFS_LIVE, 32'h3E02, 32'h0802);
      $display("test engage done");
      innerPosN <= 1'b1;
      cyc(3);
      chk("decel", decelRequest, 1'b1);
      chk("hold", contactorOn, 1'b1);
      chk("irq", irq, 1'b1);
      rdchk("inner", `OFS_STATUS, 32'h8, 32'h8);
      wr(`OFS_STATUS, 32'h3F);
      innerPosN <= 1'b0;
      cyc(3);
      chk("decel", decelRequest, 1'b0);
      chk("irqclr", irq, 1'b0);
      rdchk("back", `OFS_LIVE, 32'h3E00, 32'h0800);
      wr(`OFS_CTRL, 32'h1);
      innerPosN <= 1'b1;
      cyc(3);
      chk("noinner", decelRequest, 1'b0);
      chk("nohold", contactorOn, 1'b1);
      innerPosN <= 1'b0;
      wr(`OFS_CTRL, 32'h7);
      $display("test inner done");
      outerNegN <= 1'b1;
      cyc(3);
      chk("cont", contactorOn, 1'b0);
      chk("amp", ampEnable, 1'b0);
      rdchk("outer", `OFS_STATUS, 32'h4, 32'h4);
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_CTRL, 32'h7);
      cyc(4);
      chk("refuse", contactorOn, 1'b0);
      rdchk("open", `OFS_LIVE, 32'h20, 32'h20);
      outerNegN <= 1'b0;
      cyc(4);
      chk("closed", contactorOn, 1'b1);
      $display("test outer done");
      wr(`OFS_CTRL, 32'h0);
      fbStuck <= 1'b1;
      wr(`OFS_STATUS, 32'h3F);
      wr(`OFS_CTRL, 32'h7);
      cyc(3);
      chk("wait", contactorOn, 1'b1);
      cyc(10);
      chk("cfault", contactorOn, 1'b0);
      rdchk("cstat", `OFS_STATUS, 32'h1, 32'h1);
      fbStuck <= 1'b0;
      $display("test contactor done");
      rearm();
      ampFault <= 1'b1;
      cyc(3);
      chk("afault", contactorOn, 1'b0);
      rdchk("astat", `OFS_STATUS, 32'h2, 32'h2);
      rdchk("alive", `OFS_LIVE, 32'h1, 32'h0);
      ampFault <= 1'b0;
      $display("test amplifier done");
      rearm();
      estopIn <= 1'b1;
      cyc(2);
      chk("loop", loopOut, 1'b1);
      cyc(2);
      chk("etrip", contactorOn, 1'b0);
      rdchk("ack", `OFS_STATUS, 32'h10, 32'h10);
      rdchk("elive", `OFS_LIVE, 32'h4, 32'h4);
      estopIn <= 1'b0;
      estopClear <= 1'b1;
      cyc(2);
      estopClear <= 1'b0;
      cyc(4);
      chk("recover", contactorOn, 1'b1);
      wr(`OFS_MASK, 32'h0);
      cyc(1);
      chk("masked", irq, 1'b0);
      $display("test estop done");
      nrst <= 1'b0;
      axisModeSel <= 1'b0;
      refOrOuterPosN <= 1'b1;
      outerNegN <= 1'b1;
      cyc(2);
      nrst <= 1'b1;
      cyc(2);
      refOrOuterPosN <= 1'b0;
      cyc(3);
      rdchk("ref", `OFS_STATUS, 32'h20, 32'h20);
      rdchk("table", `OFS_LIVE, 32'h48, 32'h08);
      wr(`OFS_CTRL, 32'h7);
      cyc(6);
      chk("nolimit", contactorOn, 1'b1);
      $display("test table done");
      complete_run();
   end
endmodule // extra_axis_drive_interlock_tb_top
